// >>> design/fim_pkg.sv
// How it works
// RULE1 - Four fast pins, each handles pulse trains up to 500 Hz, any use.
// RULE2 - Pins 0/1 form pair 0, pins 2/3 pair 1; lower is A.
// RULE3 - Frequency meter: select 0..3, init high sets up, low runs.
// RULE4 - Count rising edges over gate window, report 16-bit hertz.
// RULE5 - Software picks short window for fast, long for slow signals.
// RULE6 - Period meter: time between rising edges in ms, select 0..3, 16-bit.
// RULE7 - Period range tops out at 65535 ms, about 0.015 Hz.
// RULE8 - Period meter init high sets up, low lets measurement run.
// RULE9 - Encoder: pair select 0/1, init high configures, low counts.
// RULE10 - Preset strobe loads 16-bit preset and holds it while high.
// RULE11 - Software drops preset strobe so counting resumes.
// RULE12 - Encoder count shown continuously on count output.
// RULE13 - Up/down flag set when count moved that way last program cycle.
// RULE14 - Flag cleared in program cycle after counting stops.
// RULE15 - Software debounces a fast pin used as plain input.
// RULE16 - Quadrature decode, A leading counts up, wraps modulo 65536.
// RULE17 - One-cycle program-cycle strobe delimits direction flag intervals.
// RULE18 - Two-stage synchroniser on each pin before edge detection.
package fim_pkg;
    localparam int NUM_PINS = 4;
    localparam int NUM_PAIRS = 2;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register word addresses
    localparam logic [3:0] FREQ_CTRL_ADDR = 4'h0;
    localparam logic [3:0] GATE_WINDOW_ADDR = 4'h1;
    localparam logic [3:0] PERIOD_CTRL_ADDR = 4'h2;
    localparam logic [3:0] QUAD_CTRL_ADDR = 4'h3;
    localparam logic [3:0] PRESET_VALUE_ADDR = 4'h4;
    localparam logic [3:0] PROG_CYCLE_ADDR = 4'h5;
    localparam logic [3:0] FREQ_RESULT_ADDR = 4'h8;
    localparam logic [3:0] PERIOD_RESULT_ADDR = 4'h9;
    localparam logic [3:0] QUAD_COUNT_ADDR = 4'hA;
    localparam logic [3:0] QUAD_FLAGS_ADDR = 4'hB;

    // Field positions
    localparam int INIT_BIT = 0;
    localparam int SEL_LSB = 1;
    localparam int SEL_MSB = 2;
    localparam int PAIR_BIT = 1;
    localparam int PRESET_BIT = 2;
    localparam int STROBE_BIT = 0;
    localparam int UP_BIT = 0;
    localparam int DOWN_BIT = 1;

    // Reset values
    localparam logic [15:0] GATE_WINDOW_RST = 16'h03E8;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] ONE16 = 16'h0001;
    localparam logic [15:0] MAX16 = 16'hFFFF;

    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [25:0] MS_PER_S = 26'h00003E8;

    typedef enum logic [1:0] {
        FREQ_HOLD = 2'b01,
        FREQ_GATE = 2'b10
    } freq_state_t;

    typedef enum logic [2:0] {
        PER_HOLD = 3'b001,
        PER_ARM = 3'b010,
        PER_TIME = 3'b100
    } per_state_t;
endpackage

// >>> design/fast_edge_if.sv
// Synchronised pin levels and their rising-edge pulses
interface fast_edge_if;
    logic [fim_pkg::NUM_PINS-1:0] level;
    logic [fim_pkg::NUM_PINS-1:0] rise;
    modport src (output level, output rise);
    modport dst (input level, input rise);
endinterface

// >>> design/fast_pin_sync.sv
module fast_pin_sync (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Raw pins
    input wire logic [fim_pkg::NUM_PINS-1:0] i_fast_input_pin,
    // Synchronised side
    fast_edge_if.src edges
);
    genvar g;
    generate
        for (g = 0; g < fim_pkg::NUM_PINS; g++) begin : g_pin
            logic meta_q;
            logic sync_q;
            logic last_q;
            // First stage feeds only the second stage
            always_ff @(posedge i_sys_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    last_q <= 1'b0;
                end else begin
                    meta_q <= i_fast_input_pin[g]; // [RULE18]
                    sync_q <= meta_q;
                    last_q <= sync_q;
                end
            end
            // Edge seen only on synchronised samples
            assign edges.level[g] = sync_q;
            assign edges.rise[g] = sync_q & ~last_q; // [RULE18]
        end
    endgenerate
endmodule

// >>> design/quad_step.sv
module quad_step (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Synchronised phases
    input wire logic i_phase_a,
    input wire logic i_phase_b,
    // Step pulses
    output logic o_inc,
    output logic o_dec
);
    logic [1:0] prev_q;
    logic [1:0] cur;

    // Forward order of {A,B}: 00, 10, 11, 01
    function automatic logic is_forward(input logic [1:0] from, input logic [1:0] to);
        return (from == 2'h0 && to == 2'h2) || (from == 2'h2 && to == 2'h3) ||
               (from == 2'h3 && to == 2'h1) || (from == 2'h1 && to == 2'h0);
    endfunction

    assign cur = {i_phase_a, i_phase_b};
    // Illegal double steps are ignored
    assign o_inc = is_forward(prev_q, cur); // [RULE16]
    assign o_dec = is_forward(cur, prev_q); // [RULE16]

    // Previous phase state
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            prev_q <= 2'h0;
        end else begin
            prev_q <= cur;
        end
    end
endmodule

// >>> design/fast_input_meter.sv
module fast_input_meter #(
    parameter int unsigned MS_CYCLES = fim_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Fast pins
    input wire logic [fim_pkg::NUM_PINS-1:0] i_fast_input_pin,
    // Register port
    input wire logic [fim_pkg::ADDR_W-1:0] i_addr,
    input wire logic [fim_pkg::DATA_W-1:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [fim_pkg::DATA_W-1:0] o_rd_data,
    // Measurement results
    output logic [15:0] o_freq_hz,
    output logic [15:0] o_period_ms,
    output logic [15:0] o_quad_count,
    output logic o_quad_up,
    output logic o_quad_down
);
    // Address match for write and read decode
    function automatic logic hit(input logic [fim_pkg::ADDR_W-1:0] a, input logic [fim_pkg::ADDR_W-1:0] off);
        return a == off;
    endfunction

    // Last count of the ms prescalers
    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    fast_edge_if edges ();

    // Pin synchroniser and edge detector
    fast_pin_sync u_sync (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_fast_input_pin(i_fast_input_pin), // [RULE1]
        .edges(edges)
    );

    // Quadrature decoders, one per pair
    logic [fim_pkg::NUM_PAIRS-1:0] pair_inc;
    logic [fim_pkg::NUM_PAIRS-1:0] pair_dec;
    genvar p;
    generate
        for (p = 0; p < fim_pkg::NUM_PAIRS; p++) begin : g_pair
            quad_step u_step (
                .i_sys_clk(i_sys_clk),
                .i_nrst(i_nrst),
                .i_phase_a(edges.level[2 * p]), // [RULE2]
                .i_phase_b(edges.level[2 * p + 1]), // [RULE2]
                .o_inc(pair_inc[p]),
                .o_dec(pair_dec[p])
            );
        end
    endgenerate

    // Control registers written by software
    logic freq_init_q;
    logic [1:0] freq_sel_q;
    logic [15:0] gate_window_q;
    logic per_init_q;
    logic [1:0] per_sel_q;
    logic quad_init_q;
    logic quad_pair_q;
    logic quad_preset_q;
    logic [15:0] preset_value_q;

    // Write decode
    logic wr_freq_ctrl;
    logic wr_gate;
    logic wr_per_ctrl;
    logic wr_quad_ctrl;
    logic wr_preset;
    logic prog_cycle;
    assign wr_freq_ctrl = i_wr_en & hit(i_addr, fim_pkg::FREQ_CTRL_ADDR);
    assign wr_gate = i_wr_en & hit(i_addr, fim_pkg::GATE_WINDOW_ADDR);
    assign wr_per_ctrl = i_wr_en & hit(i_addr, fim_pkg::PERIOD_CTRL_ADDR);
    assign wr_quad_ctrl = i_wr_en & hit(i_addr, fim_pkg::QUAD_CTRL_ADDR);
    assign wr_preset = i_wr_en & hit(i_addr, fim_pkg::PRESET_VALUE_ADDR);
    // Program-cycle boundary is one write, so one cycle long
    assign prog_cycle = i_wr_en & hit(i_addr, fim_pkg::PROG_CYCLE_ADDR)
                      & i_wr_data[fim_pkg::STROBE_BIT]; // [RULE17]

    // Control registers; init bits reset high so nothing runs unconfigured
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            freq_init_q <= 1'b1;
            freq_sel_q <= 2'h0;
            gate_window_q <= fim_pkg::GATE_WINDOW_RST;
            per_init_q <= 1'b1;
            per_sel_q <= 2'h0;
            quad_init_q <= 1'b1;
            quad_pair_q <= 1'b0;
            quad_preset_q <= 1'b0;
            preset_value_q <= fim_pkg::ZERO16;
        end else begin
            if (wr_freq_ctrl) begin
                freq_init_q <= i_wr_data[fim_pkg::INIT_BIT];
                freq_sel_q <= i_wr_data[fim_pkg::SEL_MSB:fim_pkg::SEL_LSB];
            end
            if (wr_gate) begin
                gate_window_q <= i_wr_data;
            end
            if (wr_per_ctrl) begin
                per_init_q <= i_wr_data[fim_pkg::INIT_BIT];
                per_sel_q <= i_wr_data[fim_pkg::SEL_MSB:fim_pkg::SEL_LSB];
            end
            if (wr_quad_ctrl) begin
                quad_init_q <= i_wr_data[fim_pkg::INIT_BIT];
                quad_pair_q <= i_wr_data[fim_pkg::PAIR_BIT];
                quad_preset_q <= i_wr_data[fim_pkg::PRESET_BIT]; // [RULE11]
            end
            if (wr_preset) begin
                preset_value_q <= i_wr_data;
            end
        end
    end

    // Frequency meter
    fim_pkg::freq_state_t freq_state_q;
    fim_pkg::freq_state_t freq_state_d;
    logic [1:0] freq_chan_q;
    logic [15:0] freq_sub_q;
    logic [15:0] freq_ms_q;
    logic [15:0] freq_edges_q;
    logic [15:0] freq_hz_q;

    logic freq_rise;
    logic freq_tick;
    logic freq_end;
    logic [15:0] freq_edges_now;
    logic [15:0] window_eff;
    logic [25:0] freq_scaled;
    logic [25:0] freq_quot;
    logic [15:0] freq_sat;

    // Selected pin edge, prescaler tick and end of gate window
    assign freq_rise = edges.rise[freq_chan_q]; // [RULE4]
    assign freq_tick = freq_sub_q == MS_LAST;
    // Zero window treated as one ms to keep the divider defined
    assign window_eff = (gate_window_q == fim_pkg::ZERO16) ? fim_pkg::ONE16 : gate_window_q;
    assign freq_end = freq_tick & (freq_ms_q + fim_pkg::ONE16 >= window_eff);
    // Edge in the closing cycle still belongs to this window
    assign freq_edges_now = (freq_rise && freq_edges_q != fim_pkg::MAX16) ?
                            freq_edges_q + fim_pkg::ONE16 : freq_edges_q;
    // Hertz = edges * 1000 / window; one wide combinational divider
    assign freq_scaled = {10'h000, freq_edges_now} * fim_pkg::MS_PER_S; // [RULE4]
    assign freq_quot = freq_scaled / {10'h000, window_eff};
    assign freq_sat = (freq_quot > {10'h000, fim_pkg::MAX16}) ? fim_pkg::MAX16 : freq_quot[15:0];

    // Init holds set-up, release starts the first window
    always_comb begin
        freq_state_d = freq_state_q;
        case (freq_state_q)
            fim_pkg::FREQ_HOLD: begin
                if (!freq_init_q) begin
                    freq_state_d = fim_pkg::FREQ_GATE; // [RULE3]
                end
            end
            fim_pkg::FREQ_GATE: begin
                if (freq_init_q) begin
                    freq_state_d = fim_pkg::FREQ_HOLD; // [RULE3]
                end
            end
            default: begin
                freq_state_d = fim_pkg::FREQ_HOLD;
            end
        endcase
    end

    // Gate window counters and result latch
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            freq_state_q <= fim_pkg::FREQ_HOLD;
            freq_chan_q <= 2'h0;
            freq_sub_q <= fim_pkg::ZERO16;
            freq_ms_q <= fim_pkg::ZERO16;
            freq_edges_q <= fim_pkg::ZERO16;
            freq_hz_q <= fim_pkg::ZERO16;
        end else begin
            freq_state_q <= freq_state_d;
            if (freq_state_q != fim_pkg::FREQ_GATE) begin
                freq_chan_q <= freq_sel_q; // [RULE3]
                freq_sub_q <= fim_pkg::ZERO16;
                freq_ms_q <= fim_pkg::ZERO16;
                freq_edges_q <= fim_pkg::ZERO16;
            end else if (freq_end) begin
                freq_hz_q <= freq_sat; // [RULE4]
                freq_sub_q <= fim_pkg::ZERO16;
                freq_ms_q <= fim_pkg::ZERO16;
                freq_edges_q <= fim_pkg::ZERO16;
            end else begin
                freq_sub_q <= freq_tick ? fim_pkg::ZERO16 : freq_sub_q + fim_pkg::ONE16;
                freq_ms_q <= freq_tick ? freq_ms_q + fim_pkg::ONE16 : freq_ms_q;
                freq_edges_q <= freq_edges_now; // [RULE4]
            end
        end
    end

    // Period meter
    fim_pkg::per_state_t per_state_q;
    fim_pkg::per_state_t per_state_d;
    logic [1:0] per_chan_q;
    logic [15:0] per_sub_q;
    logic [15:0] per_ms_q;
    logic [15:0] period_q;

    logic per_rise;
    logic per_tick;
    logic per_full;

    assign per_rise = edges.rise[per_chan_q]; // [RULE6]
    assign per_tick = per_sub_q == MS_LAST;
    // Count stops at the top of the 16-bit range
    assign per_full = per_ms_q == fim_pkg::MAX16; // [RULE7]

    // Set-up, wait for first edge, then time edge to edge
    always_comb begin
        per_state_d = per_state_q;
        case (per_state_q)
            fim_pkg::PER_HOLD: begin
                if (!per_init_q) begin
                    per_state_d = fim_pkg::PER_ARM; // [RULE8]
                end
            end
            fim_pkg::PER_ARM: begin
                if (per_init_q) begin
                    per_state_d = fim_pkg::PER_HOLD;
                end else if (per_rise) begin
                    per_state_d = fim_pkg::PER_TIME;
                end
            end
            fim_pkg::PER_TIME: begin
                if (per_init_q) begin
                    per_state_d = fim_pkg::PER_HOLD; // [RULE8]
                end
            end
            default: begin
                per_state_d = fim_pkg::PER_HOLD;
            end
        endcase
    end

    // Sub-ms prescaler restarts at each edge, no phase skew
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            per_state_q <= fim_pkg::PER_HOLD;
            per_chan_q <= 2'h0;
            per_sub_q <= fim_pkg::ZERO16;
            per_ms_q <= fim_pkg::ZERO16;
            period_q <= fim_pkg::ZERO16;
        end else begin
            per_state_q <= per_state_d;
            if (per_state_q == fim_pkg::PER_HOLD) begin
                per_chan_q <= per_sel_q; // [RULE8]
                per_sub_q <= fim_pkg::ZERO16;
                per_ms_q <= fim_pkg::ZERO16;
            end else if (per_rise) begin
                if (per_state_q == fim_pkg::PER_TIME) begin
                    period_q <= per_ms_q; // [RULE6]
                end
                per_sub_q <= fim_pkg::ZERO16;
                per_ms_q <= fim_pkg::ZERO16;
            end else begin
                per_sub_q <= per_tick ? fim_pkg::ZERO16 : per_sub_q + fim_pkg::ONE16;
                if (per_tick && !per_full) begin
                    per_ms_q <= per_ms_q + fim_pkg::ONE16;
                end
                // A stalled signal shows out of range, not a stale value
                if (per_full && per_state_q == fim_pkg::PER_TIME) begin
                    period_q <= fim_pkg::MAX16; // [RULE7]
                end
            end
        end
    end

    // Encoder counter
    logic quad_chan_q;
    logic [15:0] quad_count_q;
    logic up_seen_q;
    logic down_seen_q;
    logic quad_up_q;
    logic quad_down_q;

    logic step_inc;
    logic step_dec;
    logic counting;

    // Chosen pair counts only when active, not presetting
    assign counting = ~quad_init_q & ~quad_preset_q; // [RULE9]
    assign step_inc = counting & pair_inc[quad_chan_q];
    assign step_dec = counting & pair_dec[quad_chan_q];

    // Count, preset and pair latch
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            quad_chan_q <= 1'b0;
            quad_count_q <= fim_pkg::ZERO16;
        end else begin
            if (quad_init_q) begin
                quad_chan_q <= quad_pair_q; // [RULE9]
            end
            if (quad_preset_q) begin
                quad_count_q <= preset_value_q; // [RULE10]
            end else if (step_inc) begin
                quad_count_q <= quad_count_q + fim_pkg::ONE16; // [RULE16]
            end else if (step_dec) begin
                quad_count_q <= quad_count_q - fim_pkg::ONE16; // [RULE16]
            end
        end
    end

    // Direction seen this program cycle; boundary step kept
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            up_seen_q <= 1'b0;
            down_seen_q <= 1'b0;
            quad_up_q <= 1'b0;
            quad_down_q <= 1'b0;
        end else if (quad_init_q) begin
            up_seen_q <= 1'b0;
            down_seen_q <= 1'b0;
            quad_up_q <= 1'b0;
            quad_down_q <= 1'b0;
        end else begin
            up_seen_q <= step_inc | (up_seen_q & ~prog_cycle); // [RULE17]
            down_seen_q <= step_dec | (down_seen_q & ~prog_cycle); // [RULE17]
            if (prog_cycle) begin
                quad_up_q <= up_seen_q; // [RULE13] [RULE14]
                quad_down_q <= down_seen_q; // [RULE13] [RULE14]
            end
        end
    end

    // Read port
    logic [15:0] rd_mux;
    logic [15:0] rd_data_q;

    // Unmapped and write-only words read as zero
    assign rd_mux =
        hit(i_addr, fim_pkg::FREQ_CTRL_ADDR) ? {13'h0, freq_sel_q, freq_init_q} :
        hit(i_addr, fim_pkg::GATE_WINDOW_ADDR) ? gate_window_q :
        hit(i_addr, fim_pkg::PERIOD_CTRL_ADDR) ? {13'h0, per_sel_q, per_init_q} :
        hit(i_addr, fim_pkg::QUAD_CTRL_ADDR) ? {13'h0, quad_preset_q, quad_pair_q, quad_init_q} :
        hit(i_addr, fim_pkg::PRESET_VALUE_ADDR) ? preset_value_q :
        hit(i_addr, fim_pkg::FREQ_RESULT_ADDR) ? freq_hz_q :
        hit(i_addr, fim_pkg::PERIOD_RESULT_ADDR) ? period_q :
        hit(i_addr, fim_pkg::QUAD_COUNT_ADDR) ? quad_count_q :
        hit(i_addr, fim_pkg::QUAD_FLAGS_ADDR) ? {14'h0, quad_down_q, quad_up_q} :
        fim_pkg::ZERO16;

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_data_q <= fim_pkg::ZERO16;
        end else begin
            rd_data_q <= i_rd_en ? rd_mux : fim_pkg::ZERO16;
        end
    end

    // Outputs, all from flip-flops
    assign o_rd_data = rd_data_q;
    assign o_freq_hz = freq_hz_q;
    assign o_period_ms = period_q;
    assign o_quad_count = quad_count_q; // [RULE12]
    assign o_quad_up = quad_up_q;
    assign o_quad_down = quad_down_q;
endmodule

// >>> testbench/fim_monitor.sv
module fim_monitor (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [15:0] o_rd_data,
    // Results
    input wire logic [15:0] o_freq_hz,
    input wire logic [15:0] o_period_ms,
    input wire logic [15:0] o_quad_count,
    input wire logic o_quad_up,
    input wire logic o_quad_down
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    // Read port mirrors the live result outputs
    property p_rd_cnt;
        i_rd_en && i_addr == fim_pkg::QUAD_COUNT_ADDR |=> o_rd_data == $past(o_quad_count);
    endproperty
    a_rd_cnt: assert property (p_rd_cnt) else $error("count read mismatch");
    property p_rd_freq;
        i_rd_en && i_addr == fim_pkg::FREQ_RESULT_ADDR |=> o_rd_data == $past(o_freq_hz);
    endproperty
    a_rd_freq: assert property (p_rd_freq) else $error("freq read mismatch");
    property p_rd_per;
        i_rd_en && i_addr == fim_pkg::PERIOD_RESULT_ADDR |=> o_rd_data == $past(o_period_ms);
    endproperty
    a_rd_per: assert property (p_rd_per) else $error("period read mismatch");
    property p_rd_flags;
        i_rd_en && i_addr == fim_pkg::QUAD_FLAGS_ADDR
            |=> o_rd_data == {14'h0000, $past(o_quad_down), $past(o_quad_up)};
    endproperty
    a_rd_flags: assert property (p_rd_flags) else $error("flag read mismatch");
    // Data only in the cycle after a read
    property p_rd_idle;
        !$past(i_rd_en) |-> o_rd_data == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_rd_hole;
        i_rd_en && i_addr == 4'h7 |=> o_rd_data == 16'h0000;
    endproperty
    a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
    // Away from writes the count moves one step at a time
    property p_step;
        $changed(o_quad_count) && !$past(i_wr_en) && !$past(i_wr_en, 2) && !$past(i_wr_en, 3)
            |-> o_quad_count == $past(o_quad_count) + 16'h0001
            || o_quad_count == $past(o_quad_count) - 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("count jumped");
    // Flags move only just after a write
    property p_flag_time;
        $changed({o_quad_up, o_quad_down}) |-> $past(i_wr_en) || $past(i_wr_en, 2);
    endproperty
    a_flag_time: assert property (p_flag_time) else $error("flags moved off boundary");
endmodule

bind fast_input_meter fim_monitor u_mon (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
    .o_freq_hz(o_freq_hz), .o_period_ms(o_period_ms), .o_quad_count(o_quad_count), .o_quad_up(o_quad_up),
    .o_quad_down(o_quad_down));

// >>> testbench/pulse_quad_model.sv
module pulse_quad_model (
    // Clock
    input wire logic i_sys_clk,
    // Control
    input wire logic i_quad,
    input wire logic [1:0] i_sel,
    input wire logic [7:0] i_half,
    input wire logic i_dir,
    input wire logic [7:0] i_steps,
    // Pins
    output logic [3:0] o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt = 8'h00;
    logic [7:0] left = 8'h00;
    logic [1:0] ph = 2'h0;
    logic [1:0] po = 2'h0;
    logic sq = 1'h0;
    logic dec = 1'h0;
    // Square wave, decoys flip every cycle; other pair runs backwards
    always @(posedge i_sys_clk) begin
        dec <= ~dec;
        cnt <= (cnt >= i_half - 8'h01) ? 8'h00 : cnt + 8'h01;
        if (cnt == 8'h00) sq <= ~sq;
        if (i_steps != 8'h00) left <= i_steps;
        else if (cnt == 8'h00 && left != 8'h00) begin
            ph <= i_dir ? ph + 2'h1 : ph - 2'h1;
            po <= i_dir ? po - 2'h1 : po + 2'h1;
            left <= left - 8'h01;
        end
    end
    // Gray phases: A low pin, B high pin of each pair
    always_comb begin
        if (i_quad && i_sel[0]) o_pin = {ph[1], ph[0] ^ ph[1], po[1], po[0] ^ po[1]};
        else if (i_quad) o_pin = {po[1], po[0] ^ po[1], ph[1], ph[0] ^ ph[1]};
        else begin
            o_pin = {4{dec}};
            o_pin[i_sel] = sq;
        end
    end
endmodule

// >>> testbench/tb_fast_input_freq_period_encoder.sv
module tb_fast_input_freq_period_encoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 1'h0, i_nrst = 1'h0;
    logic [3:0] pins, i_addr = 4'h0;
    logic [15:0] i_wr_data = 16'h0000;
    logic i_wr_en = 1'h0, i_rd_en = 1'h0;
    logic [15:0] o_rd_data, o_freq_hz, o_period_ms, o_quad_count;
    logic o_quad_up, o_quad_down;
    logic m_quad = 1'h0, m_dir = 1'h0;
    logic [1:0] m_sel = 2'h0;
    logic [7:0] m_half = 8'h08, m_steps = 8'h00;
    int n_errors = 0, cmp_count = 0;
    typedef struct {logic [1:0] pin; logic [7:0] half; logic [15:0] f; logic [15:0] p;} row_t;
    // 48 ms window, periods of 1.6, 3.2, 4.8, 9.6 ms at 10 cycles per ms
    row_t rows[4] = '{'{2'h0, 8'h08, 16'h0271, 16'h0001}, '{2'h1, 8'h10, 16'h0138, 16'h0003},
        '{2'h2, 8'h18, 16'h00D0, 16'h0004}, '{2'h3, 8'h30, 16'h0068, 16'h0009}};

    always #12.5 i_sys_clk = ~i_sys_clk;

    fast_input_meter #(.MS_CYCLES(10)) uut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_fast_input_pin(pins),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
        .o_freq_hz(o_freq_hz), .o_period_ms(o_period_ms), .o_quad_count(o_quad_count), .o_quad_up(o_quad_up),
        .o_quad_down(o_quad_down));
    pulse_quad_model model (.i_sys_clk(i_sys_clk), .i_quad(m_quad), .i_sel(m_sel), .i_half(m_half),
        .i_dir(m_dir), .i_steps(m_steps), .o_pin(pins));

    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            n_errors++;
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr_en <= 1'h1;
        @(posedge i_sys_clk);
        i_wr_en <= 1'h0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd_en <= 1'h1;
        @(posedge i_sys_clk);
        i_rd_en <= 1'h0;
        @(negedge i_sys_clk);
        chk(o_rd_data, exp);
    endtask
    // Encoder step burst on the far side, then settle
    task move(input logic dir, input logic [7:0] n);
        @(posedge i_sys_clk);
        m_dir <= dir;
        m_steps <= n;
        @(posedge i_sys_clk);
        m_steps <= 8'h00;
        repeat (8 * n + 12) @(negedge i_sys_clk);
    endtask
    task boundary(input logic [1:0] exp);
        wr(fim_pkg::PROG_CYCLE_ADDR, 16'h0001);
        repeat (4) @(negedge i_sys_clk);
        chk({14'h0000, o_quad_down, o_quad_up}, {14'h0000, exp});
    endtask
    task give_verdict;
        $display("errors %0d, compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge i_sys_clk);
        n_errors++;
        give_verdict;
    end

    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_nrst <= 1'h1;
        wr(fim_pkg::GATE_WINDOW_ADDR, 16'h0030);
        // Frequency and period, one pin per row, decoys on the rest
        foreach (rows[i]) begin
            m_sel <= rows[i].pin;
            m_half <= rows[i].half;
            wr(fim_pkg::FREQ_CTRL_ADDR, {13'h0000, rows[i].pin, 1'h1});
            wr(fim_pkg::PERIOD_CTRL_ADDR, {13'h0000, rows[i].pin, 1'h1});
            wr(fim_pkg::FREQ_CTRL_ADDR, {13'h0000, rows[i].pin, 1'h0});
            wr(fim_pkg::PERIOD_CTRL_ADDR, {13'h0000, rows[i].pin, 1'h0});
            repeat (1100) @(negedge i_sys_clk);
            chk(o_freq_hz, rows[i].f);
            rd(fim_pkg::FREQ_RESULT_ADDR, rows[i].f);
            chk(o_period_ms, rows[i].p);
            rd(fim_pkg::PERIOD_RESULT_ADDR, rows[i].p);
        end
        // Encoder on each pair: preset, hold, wrap, flags
        m_quad <= 1'h1;
        m_half <= 8'h06;
        for (int p = 0; p < 2; p++) begin
            m_sel <= p[1:0];
            wr(fim_pkg::QUAD_CTRL_ADDR, {14'h0000, p[0], 1'h1});
            wr(fim_pkg::PRESET_VALUE_ADDR, 16'hFFFE);
            wr(fim_pkg::QUAD_CTRL_ADDR, {13'h0000, 1'h1, p[0], 1'h0});
            move(1'h1, 8'h02);
            rd(fim_pkg::QUAD_COUNT_ADDR, 16'hFFFE);
            wr(fim_pkg::QUAD_CTRL_ADDR, {14'h0000, p[0], 1'h0});
            boundary(2'h0);
            move(1'h1, 8'h04);
            chk(o_quad_count, 16'h0002);
            boundary(2'h1);
            boundary(2'h0);
            move(1'h0, 8'h03);
            rd(fim_pkg::QUAD_COUNT_ADDR, 16'hFFFF);
            boundary(2'h2);
            rd(fim_pkg::QUAD_FLAGS_ADDR, 16'h0002);
        end
        // Second reset, defaults and odd accesses
        @(posedge i_sys_clk);
        i_nrst <= 1'h0;
        repeat (2) @(posedge i_sys_clk);
        i_nrst <= 1'h1;
        chk(o_quad_count, 16'h0000);
        rd(fim_pkg::GATE_WINDOW_ADDR, 16'h03E8);
        rd(fim_pkg::FREQ_CTRL_ADDR, 16'h0001);
        rd(fim_pkg::QUAD_CTRL_ADDR, 16'h0001);
        wr(fim_pkg::FREQ_RESULT_ADDR, 16'h1234);
        rd(fim_pkg::FREQ_RESULT_ADDR, 16'h0000);
        rd(fim_pkg::PROG_CYCLE_ADDR, 16'h0000);
        rd(4'h7, 16'h0000);
        give_verdict;
    end
endmodule
